// [logic/tv_sync_countdown.sv]
// Purpose: count-down line and field timing of a deflection processor
// Assumes: oscillator, sync and flyback inputs synchronous to mclk
// Notes: oscClk is sampled; its rising edge is the squared clock tick
`timescale 1ns/100ps
`include "tv_sync_map.svh"

// What this block does
// - square oscillator input and divide by sixteen to twice line rate
// - halve twice line rate into open-drain line square wave
// - reset flop on twice line rate clears vertical count chain
// - reset flop input is vertical sync gated by window and timeout
// - ignore vertical sync until 510 cycles after the last reset
// - sync inside window causes reset on next twice-line-rate cycle
// - no sync by 542 cycles makes timeout gate start a reset
// - every vertical reset pulses the retrace timing section
// - discharge ramp during retrace until external timer completes
// - phase compare only during low sync; up or down by saw phase
// - burst gate clamped in flyback first half, released at peak
module tv_sync_countdown #(
	parameter int PRE_DIV = `PRESCALE_DIV,
	parameter int OPEN_CNT = `WINDOW_OPEN,
	parameter int TIMEOUT_CNT = `WINDOW_TIMEOUT
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// oscillator and sync inputs
	input wire logic oscClk,
	input wire logic vSync,
	input wire logic hSyncN,
	// flyback and external retrace timer
	input wire logic flybackActive,
	input wire logic sawAboveMid,
	input wire logic retraceDone,
	// outputs
	output logic lineOut,
	output logic lineOe,
	output logic rampDischarge,
	output logic retracePulse,
	output logic phaseUp,
	output logic phaseDown,
	output logic burstClampOe
);
	// ---------------------------------------------------------------
	// checks and state
	// ---------------------------------------------------------------
	// parameter guard: prescaler is four bits, count chain ten bits
	if (PRE_DIV < 1 || PRE_DIV > `PRESCALE_DIV || OPEN_CNT < 1 ||
		TIMEOUT_CNT <= OPEN_CNT ||
		TIMEOUT_CNT >= (1 << `VCOUNT_MIN_W)) begin : g_bad_param
		$error("tv_sync_countdown: unsupported parameters");
	end

	tv_sync_pkg::sync_state_t s_q, s_d;
	logic oscTick;
	logic twoLineTick;
	logic [9:0] elapsed;
	logic windowOpen;
	logic timeoutHit;

	// rising edge of the squared oscillator, one mclk wide
	assign oscTick = oscClk & ~s_q.oscPrev;
	// every PRE_DIV oscillator edges make one twice-line-rate tick
	assign twoLineTick = oscTick &&
		(s_q.prescale == 4'(PRE_DIV - 1));
	// ticks since the last vertical reset, this tick included
	assign elapsed = s_q.vCount + 10'h001;
	// sync gate opens once the window count has elapsed
	assign windowOpen = elapsed >= 10'(OPEN_CNT);
	// timeout gate sets the flop one tick before the period ends
	assign timeoutHit = elapsed >= 10'(TIMEOUT_CNT - 1);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.retracePulse = 1'h0;
		// oscillator level kept for the edge detect
		s_d.oscPrev = oscClk;
		// prescaler wraps after PRE_DIV oscillator edges
		if (twoLineTick)
			s_d.prescale = 4'h0;
		else if (oscTick)
			s_d.prescale = s_q.prescale + 4'h1;
		if (twoLineTick) begin
			s_d.lineStage = ~s_q.lineStage;
			if (s_q.resetFlop) begin
				// chain cleared, so both gates close again
				s_d.vCount = 10'h000;
				s_d.resetFlop = 1'h0;
				s_d.retracePulse = 1'h1;
			end else begin
				s_d.vCount = elapsed;
				// reset request from windowed sync or timeout
				s_d.resetFlop = (vSync & windowOpen) | timeoutHit;
			end
		end
		// retrace control
		unique case (s_q.ramp)
			tv_sync_pkg::RAMP_FORM: begin
				if (s_q.retracePulse)
					s_d.ramp = tv_sync_pkg::RAMP_RETRACE;
			end
			tv_sync_pkg::RAMP_RETRACE: begin
				if (retraceDone)
					s_d.ramp = tv_sync_pkg::RAMP_FORM;
			end
		endcase
		s_d.rampDischarge = (s_d.ramp == tv_sync_pkg::RAMP_RETRACE);
		// open drain line output: drive low on half period
		s_d.lineOut = 1'b0;
		s_d.lineOe = ~s_d.lineStage;
		// phase detector gated by low sync
		s_d.phaseUp = ~hSyncN & ~sawAboveMid;
		s_d.phaseDown = ~hSyncN & sawAboveMid;
		// burst clamp until the sawtooth peak
		s_d.burstClamp = flybackActive & ~sawAboveMid;
	end

	// state register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// outputs straight from flops
	assign lineOut = s_q.lineOut;
	assign lineOe = s_q.lineOe;
	assign rampDischarge = s_q.rampDischarge;
	assign retracePulse = s_q.retracePulse;
	assign phaseUp = s_q.phaseUp;
	assign phaseDown = s_q.phaseDown;
	assign burstClampOe = s_q.burstClamp;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	// prescaler never passes its wrap value
	a_prescale_bound: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_q.prescale <= 4'(PRE_DIV - 1))
		else $error("prescaler ran past its wrap");

	// line enable flips once per twice-line-rate tick
	a_line_div: assert property (
		@(posedge mclk) disable iff (sys_rst)
		twoLineTick |=> ##1 (lineOe != $past(lineOe, 2)))
		else $error("line stage did not toggle");

	// a captured request clears the chain at the next tick
	a_chain_clears: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(twoLineTick && s_q.resetFlop) |=> (s_q.vCount == 10'h000))
		else $error("count chain not cleared on reset");

	// without sync or timeout the flop stays clear
	a_gated_reset: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(twoLineTick && !s_q.resetFlop && !vSync && !timeoutHit) |=>
		!s_q.resetFlop)
		else $error("reset request without a source");

	// sync before the window is not taken
	a_sync_ignored: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(twoLineTick && !s_q.resetFlop && elapsed < 10'(OPEN_CNT)) |=>
		!s_q.resetFlop)
		else $error("reset taken before window");

	// sync inside the window is captured at this tick
	a_sync_reset: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(twoLineTick && vSync && windowOpen && !s_q.resetFlop) |=>
		s_q.resetFlop)
		else $error("windowed sync lost");

	// timeout starts a reset on its own
	a_timeout_reset: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(twoLineTick && timeoutHit && !s_q.resetFlop) |=> s_q.resetFlop)
		else $error("timeout reset missing");

	// every chain reset issues a retrace pulse
	a_pulse_source: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(twoLineTick && s_q.resetFlop) |=> retracePulse)
		else $error("reset without retrace pulse");

	// the retrace pulse lasts one cycle
	a_pulse_single: assert property (
		@(posedge mclk) disable iff (sys_rst)
		retracePulse |=> !retracePulse)
		else $error("retrace pulse too long");

	// a retrace pulse starts the discharge
	a_retrace_start: assert property (
		@(posedge mclk) disable iff (sys_rst)
		retracePulse |=> rampDischarge)
		else $error("retrace not started");

	// timer completion releases the ramp
	a_ramp_release: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(rampDischarge && retraceDone && !retracePulse) |=> !rampDischarge)
		else $error("ramp not released");

	// discharge holds until the timer completes
	a_ramp_hold: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(rampDischarge && !retraceDone) |=> rampDischarge)
		else $error("ramp released early");

	// the ramp forms freely between retraces
	a_ramp_quiet: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(!rampDischarge && !retracePulse) |=> !rampDischarge)
		else $error("discharge without retrace pulse");

	// no correction outside horizontal sync
	a_phase_gate: assert property (
		@(posedge mclk) disable iff (sys_rst)
		$past(hSyncN) |-> !(phaseUp || phaseDown))
		else $error("phase pulse outside sync");

	// during sync the sawtooth half picks the direction
	a_phase_steer: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(!$past(sys_rst) && !$past(hSyncN)) |->
		(phaseDown == $past(sawAboveMid) && phaseUp != phaseDown))
		else $error("phase pulse steered wrongly");

	// clamp released from the flyback peak on
	a_burst_clamp: assert property (
		@(posedge mclk) disable iff (sys_rst)
		$past(sawAboveMid) |-> !burstClampOe)
		else $error("burst clamp after flyback peak");

	// clamp held through the first flyback half
	a_burst_hold: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(!$past(sys_rst) && $past(flybackActive) && !$past(sawAboveMid))
		|-> burstClampOe)
		else $error("burst clamp missing in first half");

	// chain never runs past the last count of a field
	a_count_bound: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_q.vCount <= 10'(TIMEOUT_CNT - 1))
		else $error("count chain ran past timeout");

	// chain steps by one on every tick without reset
	a_chain_step: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(twoLineTick && !s_q.resetFlop) |=>
		(s_q.vCount == $past(s_q.vCount) + 10'h001))
		else $error("count chain did not step");
endmodule : tv_sync_countdown

// [logic/tv_sync_map.svh]
// Purpose: named constants of the sync count-down block
// Assumes: included by its bare name
// Notes: counts are in twice-line-rate cycles
`ifndef TV_SYNC_MAP_SVH
`define TV_SYNC_MAP_SVH
`define PRESCALE_DIV 16
`define WINDOW_OPEN 510
`define WINDOW_TIMEOUT 542
`define VCOUNT_MIN_W 10
`endif

// [logic/tv_sync_pkg.sv]
// Purpose: types of the sync count-down block
// Assumes: nothing
// Notes: one packed struct holds all block state
package tv_sync_pkg;
	typedef enum logic [0:0] {
		RAMP_FORM = 1'h0,
		RAMP_RETRACE = 1'h1
	} ramp_state_t;
	typedef struct packed {
		logic [3:0] prescale;
		logic lineStage;
		logic resetFlop;
		logic [9:0] vCount;
		ramp_state_t ramp;
		logic lineOut;
		logic lineOe;
		logic rampDischarge;
		logic retracePulse;
		logic phaseUp;
		logic phaseDown;
		logic burstClamp;
		logic oscPrev;
	} sync_state_t;
endpackage : tv_sync_pkg

// [verif/sync_partner.sv]
// Purpose: oscillator and retrace timer beside the count-down block
// Assumes: both change just after the rising edge of mclk
// Notes: timer ends each retrace a fixed time after it starts
`timescale 1ns/100ps
module sync_partner #(
	parameter int DONE_DLY = 5
) (
	// shared clock
	input wire logic mclk,
	// retrace request in, oscillator and timer out
	input wire logic rampDischarge,
	output logic oscClk,
	output logic retraceDone
);
	int rampCnt = 0;
	logic oscQ = 1'h0;
	logic doneQ = 1'h0;
	assign oscClk = oscQ;
	assign retraceDone = doneQ;
	// oscillator toggles each cycle; timer runs while ramp discharges
	always @(posedge mclk) begin
		oscQ <= ~oscQ;
		rampCnt <= rampDischarge ? rampCnt + 1 : 0;
		doneQ <= rampDischarge && rampCnt == DONE_DLY - 2;
	end
endmodule : sync_partner

// [verif/tv_sync_countdown_tb.sv]
// Purpose: self-checking bench of the sync count-down block
// Assumes: partner drives oscillator and retrace timer
// Notes: short counts keep each field a few hundred cycles
`timescale 1ns/100ps
module tv_sync_countdown_tb;
	localparam int PD = 4, OC = 20, TC = 30, DD = 5, TK = 2 * PD;
	localparam int GAP1 = (OC + 1) * TK, GAP0 = TC * TK;
	logic mclk, sys_rst, oscClk, vSync, hSyncN, flybackActive;
	logic sawAboveMid, retraceDone, lineOut, lineOe, rampDischarge;
	logic retracePulse, phaseUp, phaseDown, burstClampOe, oePrev;
	logic [2:0] pv, outs;
	logic [16:0] lfsr;
	int n_errors, cmp_count, cyc, lastPulse, fields, rampLen, lastOe;
	int nOe, expGap;
	assign outs = {phaseUp, phaseDown, burstClampOe};
	tv_sync_countdown #(.PRE_DIV(PD), .OPEN_CNT(OC), .TIMEOUT_CNT(TC))
	u_dut (.mclk, .sys_rst, .oscClk, .vSync, .hSyncN, .flybackActive,
		.sawAboveMid, .retraceDone, .lineOut, .lineOe, .rampDischarge,
		.retracePulse, .phaseUp, .phaseDown, .burstClampOe);
	sync_partner #(.DONE_DLY(DD)) u_partner (.mclk, .rampDischarge,
		.oscClk, .retraceDone);
	function automatic logic [16:0] next_lfsr(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction : next_lfsr
	// v is {flyback, saw, hSyncN}; result is {up, down, clamp}
	function automatic logic [2:0] exp_out(input logic [2:0] v);
		return {~v[0] & ~v[1], ~v[0] & v[1], v[2] & ~v[1]};
	endfunction : exp_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// outputs are settled at the falling edge
	always @(negedge mclk) begin
		if (sys_rst) begin
			chk({lineOe, rampDischarge, retracePulse, outs}, 6'h00);
			cyc = 0;
			fields = 0;
			nOe = 0;
			rampLen = 0;
		end else begin
			cyc++;
			if (cyc > 1) chk(outs, exp_out(pv));
			chk(lineOut, 1'b0);
			if (rampDischarge === 1'b1) rampLen++;
			else if (rampLen > 0) begin
				chk(rampLen, DD);
				rampLen = 0;
			end
			if (retracePulse === 1'b1) begin
				if (fields) chk(cyc - lastPulse, expGap);
				fields++;
				lastPulse = cyc;
			end
			if (lineOe !== oePrev) begin
				if (nOe > 1) chk(cyc - lastOe, TK);
				nOe++;
				lastOe = cyc;
			end
		end
		oePrev = lineOe;
		pv = {flybackActive, sawAboveMid, hSyncN};
	end
	// each test resets, then holds sync low (timeout) or high (early)
	initial begin
		sys_rst = 1'h1;
		{flybackActive, sawAboveMid, hSyncN} = 3'h1;
		lfsr = 17'h1463C;
		for (int i = 0; i < 4; i++) begin
			if (i > 0) sys_rst <= 1'h1;
			vSync <= i[0];
			expGap = i[0] ? GAP1 : GAP0;
			repeat (4) @(posedge mclk);
			sys_rst <= 1'h0;
			repeat (5 * GAP0) begin
				@(posedge mclk);
				lfsr = next_lfsr(lfsr);
				{flybackActive, sawAboveMid, hSyncN} <= lfsr[2:0];
			end
			$display("test %0d done", i);
		end
		stop_test();
	end
	// watchdog at twice the expected run
	initial begin
		#(8 * 5 * GAP0 * 4);
		n_errors++;
		stop_test();
	end
endmodule : tv_sync_countdown_tb
